// ---- core/irq_pos_pkg.sv ----
// Constants and types shared by the interrupt positioning channel
`default_nettype none
package irq_pos_pkg;
   localparam int          NUM_CH        = 4;
   localparam int          CLK_HZ        = 20000000;
   localparam int          FREQ_MIN_HZ   = 10;
   localparam int          FREQ_MAX_HZ   = 100000;
   localparam logic [32:0] PRE_IRQ_LIMIT = 33'h1_0000_0000;
   localparam logic [15:0] BAD_SOURCE_ERROR_CODE = 16'h1a6b;
   // Register byte offsets
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_SRC_SEL   = 8'h04;
   localparam logic [7:0]  REG_STATUS    = 8'h08;
   localparam logic [7:0]  REG_ERR_CODE  = 8'h0c;
   localparam logic [7:0]  REG_CH_BASE   = 8'h10;
   localparam logic [7:0]  REG_CH_STRIDE = 8'h08;
   localparam logic [7:0]  REG_FREQ_OFS  = 8'h04;
   // Control word field positions
   localparam int          CTRL_SEL_EN   = 0;
   localparam int          CTRL_START    = 4;
   localparam int          CTRL_USER     = 8;
   localparam int          CTRL_INVERT   = 12;
   localparam int          CTRL_FWD_LIM  = 16;
   localparam int          CTRL_REV_LIM  = 20;
   // Status word field positions
   localparam int          STAT_BUSY     = 0;
   localparam int          STAT_DONE     = 4;
   localparam int          STAT_ABEND    = 8;
   localparam int          STAT_ERR      = 12;
   // Source select field codes
   localparam logic [3:0]  SRC_USER      = 4'h8;
   localparam logic [3:0]  SRC_UNUSED    = 4'hf;
   localparam logic [15:0] SRC_SEL_RESET = 16'hffff;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_SEEK = 4'b0010,
      S_POST = 4'b0100,
      S_STOP = 4'b1000
   } chan_state_t;

   typedef enum logic [1:0] {
      END_ABORT = 2'h0,
      END_DONE  = 2'h1,
      END_ABEND = 2'h2
   } end_kind_t;
endpackage
`default_nettype wire

// ---- core/irq_source_sel.sv ----
// Interrupt source selection and polarity for one channel
`timescale 1ns/1ps
`default_nettype none
module irq_source_sel
   import irq_pos_pkg::*;
#(
   parameter int CH = 0
) (
   input  wire logic [7:0] phys_in,
   input  wire logic       user_cmd,
   input  wire logic       sel_enable,
   input  wire logic [3:0] field,
   input  wire logic       invert,
   output logic            irq_level,
   output logic            bad_source
);
   logic raw;
   logic use_user;

   ////////////////////////////////////////////////////////////////////
   // Source mux, polarity applies to physical inputs only
   always_comb begin
      raw        = 1'b0;
      use_user   = 1'b0;
      bad_source = 1'b0;
      if (!sel_enable) begin
         raw = phys_in[CH];
      end else if (field <= 4'h7) begin
         raw = phys_in[field[2:0]];
      end else if (field == SRC_USER) begin
         use_user = 1'b1;
      end else begin
         bad_source = 1'b1;
      end
      if (use_user) begin
         irq_level = user_cmd;
      end else begin
         irq_level = raw ^ invert;
      end
   end
endmodule // irq_source_sel
`default_nettype wire

// ---- core/pulse_rate_gen.sv ----
// Square pulse generator driven by a phase accumulator
`timescale 1ns/1ps
`default_nettype none
module pulse_rate_gen
   import irq_pos_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        run,
   input  wire logic [31:0] freq,
   output logic             pulse,
   output logic             pulse_done
);
   logic [31:0] acc;
   logic [31:0] next_acc;
   logic [31:0] sum;
   logic        next_pulse;

   ////////////////////////////////////////////////////////////////////
   // Two half periods per pulse; a high phase always completes
   always_comb begin
      sum        = acc + {freq[30:0], 1'b0};
      next_acc   = acc;
      next_pulse = pulse;
      pulse_done = 1'b0;
      if (!run && !pulse) begin
         next_acc = '0;
      end else if (sum >= 32'(CLK_HZ)) begin
         next_acc   = sum - 32'(CLK_HZ);
         next_pulse = !pulse;
         pulse_done = pulse;
      end else begin
         next_acc = sum;
      end
   end

   // State registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc   <= '0;
         pulse <= 1'b0;
      end else begin
         acc   <= next_acc;
         pulse <= next_pulse;
      end
   end
endmodule // pulse_rate_gen
`default_nettype wire

// ---- core/irq_positioning.sv ----
// Interrupt triggered positioning pulse channels with register port
//
// Summary of operation
// - Selection off: channel n uses input n
// - Selection on: nibble 0..7 picks input
// - Nibble 8 picks channel user command bit
// - Nibble 9..F at start: error, no motion
// - User command on: output count, stop
// - Invert bit flips physical input polarity
// - Invert ignored for user command source
// - Pulses at frequency, direction from sign
// - After interrupt emit count pulses, halt
// - Normal halt sets completion flag
// - Frequency clamped to 10..100000 Hz
// - Interrupt active at start: relative move
// - Operands latched at start edge only
// - Start removed: stop, no completion flag
// - 2^32 pulses without interrupt: stop, complete
// - Busy channel refuses new start
// - Limit in direction: stop, abnormal flag
// - Direction high forward, low reverse
`timescale 1ns/1ps
`default_nettype none
module irq_positioning
   import irq_pos_pkg::*;
#(
   parameter logic [32:0] PRE_LIMIT = PRE_IRQ_LIMIT
) (
   input  wire logic        CLOCK,
   input  wire logic        NRST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA,
   input  wire logic [7:0]  PHYS_IN,
   output logic [3:0]       PULSE_OUT,
   output logic [3:0]       DIRECTION_OUT,
   output logic [3:0]       BUSY
);
   // Software visible state
   logic [31:0] ctrl;
   logic [31:0] next_ctrl;
   logic [15:0] src_sel;
   logic [15:0] next_src_sel;
   logic [3:0]  done_flag;
   logic [3:0]  next_done_flag;
   logic [3:0]  abend_flag;
   logic [3:0]  next_abend_flag;
   logic [3:0]  err_flag;
   logic [3:0]  next_err_flag;
   logic [15:0] err_code;
   logic [15:0] next_err_code;
   logic [31:0] count_op [NUM_CH];
   logic [31:0] next_count_op [NUM_CH];
   logic [31:0] freq_op [NUM_CH];
   logic [31:0] next_freq_op [NUM_CH];
   logic [31:0] next_rdata;
   // Per channel events and busy
   logic [3:0]  ev_done;
   logic [3:0]  ev_abend;
   logic [3:0]  ev_err;
   logic [3:0]  busy_int;

   // Byte offset of a channel operand word
   function automatic logic [7:0] ch_addr(input int ch, input logic [7:0] ofs);
      ch_addr = REG_CH_BASE + 8'(ch) * REG_CH_STRIDE + ofs;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Register write and sticky flag update, set wins over clear
   always_comb begin
      next_ctrl       = ctrl;
      next_src_sel    = src_sel;
      next_done_flag  = done_flag;
      next_abend_flag = abend_flag;
      next_err_flag   = err_flag;
      next_err_code   = err_code;
      for (int c = 0; c < NUM_CH; c++) begin
         next_count_op[c] = count_op[c];
         next_freq_op[c]  = freq_op[c];
      end
      if (WR) begin
         if (ADDR == REG_CTRL) begin
            next_ctrl = {8'h00, WDATA[23:0]};
         end
         if (ADDR == REG_SRC_SEL) begin
            next_src_sel = WDATA[15:0];
         end
         if (ADDR == REG_STATUS) begin
            next_done_flag  = done_flag & ~WDATA[STAT_DONE +: 4];
            next_abend_flag = abend_flag & ~WDATA[STAT_ABEND +: 4];
            next_err_flag   = err_flag & ~WDATA[STAT_ERR +: 4];
         end
         for (int c = 0; c < NUM_CH; c++) begin
            if (ADDR == ch_addr(c, 8'h00)) begin
               next_count_op[c] = WDATA;
            end
            if (ADDR == ch_addr(c, REG_FREQ_OFS)) begin
               next_freq_op[c] = WDATA;
            end
         end
      end
      next_done_flag  = next_done_flag | ev_done;
      next_abend_flag = next_abend_flag | ev_abend;
      next_err_flag   = next_err_flag | ev_err;
      if (|ev_err) begin
         next_err_code = BAD_SOURCE_ERROR_CODE;
      end
   end

   // Read mux, unmapped offsets read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (ADDR)
         REG_CTRL:     next_rdata = ctrl;
         REG_SRC_SEL:  next_rdata = {16'h0000, src_sel};
         REG_STATUS:   next_rdata = {16'h0000, err_flag, abend_flag, done_flag, busy_int};
         REG_ERR_CODE: next_rdata = {16'h0000, err_code};
         default: begin
            for (int c = 0; c < NUM_CH; c++) begin
               if (ADDR == ch_addr(c, 8'h00)) begin
                  next_rdata = count_op[c];
               end
               if (ADDR == ch_addr(c, REG_FREQ_OFS)) begin
                  next_rdata = freq_op[c];
               end
            end
         end
      endcase
   end

   // Register file flops
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         ctrl       <= 32'h0000_0000;
         src_sel    <= SRC_SEL_RESET;
         done_flag  <= 4'h0;
         abend_flag <= 4'h0;
         err_flag   <= 4'h0;
         err_code   <= 16'h0000;
         RDATA      <= 32'h0000_0000;
         for (int c = 0; c < NUM_CH; c++) begin
            count_op[c] <= 32'h0000_0000;
            freq_op[c]  <= 32'h0000_0000;
         end
      end else begin
         ctrl       <= next_ctrl;
         src_sel    <= next_src_sel;
         done_flag  <= next_done_flag;
         abend_flag <= next_abend_flag;
         err_flag   <= next_err_flag;
         err_code   <= next_err_code;
         RDATA      <= RD ? next_rdata : 32'h0000_0000;
         for (int c = 0; c < NUM_CH; c++) begin
            count_op[c] <= next_count_op[c];
            freq_op[c]  <= next_freq_op[c];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // One positioning engine per channel
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      chan_state_t state;
      chan_state_t next_state;
      end_kind_t   kind;
      end_kind_t   next_kind;
      logic        start;
      logic        start_prev;
      logic        irq_level;
      logic        irq_prev;
      logic        bad_source;
      logic        pulse;
      logic        pulse_done;
      logic        dir;
      logic        next_dir;
      logic [31:0] freq_l;
      logic [31:0] next_freq_l;
      logic [31:0] target;
      logic [31:0] next_target;
      logic [31:0] post_cnt;
      logic [31:0] next_post_cnt;
      logic [32:0] pre_cnt;
      logic [32:0] next_pre_cnt;
      logic        limit_hit;

      assign start = ctrl[CTRL_START + ch];

      irq_source_sel #(.CH(ch)) u_sel (
         .phys_in    (PHYS_IN),
         .user_cmd   (ctrl[CTRL_USER + ch]),
         .sel_enable (ctrl[CTRL_SEL_EN]),
         .field      (src_sel[4*ch +: 4]),
         .invert     (ctrl[CTRL_INVERT + ch]),
         .irq_level  (irq_level),
         .bad_source (bad_source)
      );

      pulse_rate_gen u_gen (
         .clk        (CLOCK),
         .rst_n      (NRST),
         .run        (state == S_SEEK || state == S_POST),
         .freq       (freq_l),
         .pulse      (pulse),
         .pulse_done (pulse_done)
      );

      // Limit in the direction of travel
      assign limit_hit = dir ? ctrl[CTRL_FWD_LIM + ch] : ctrl[CTRL_REV_LIM + ch];

      // Channel sequencer
      always_comb begin
         next_state    = state;
         next_kind     = kind;
         next_dir      = dir;
         next_freq_l   = freq_l;
         next_target   = target;
         next_post_cnt = post_cnt;
         next_pre_cnt  = pre_cnt;
         ev_done[ch]   = 1'b0;
         ev_abend[ch]  = 1'b0;
         ev_err[ch]    = 1'b0;
         case (state)
            S_IDLE: begin
               if (start && !start_prev) begin
                  if (bad_source) begin
                     ev_err[ch] = 1'b1;
                  end else begin
                     next_dir    = !count_op[ch][31];
                     next_target = count_op[ch][31] ? -count_op[ch] : count_op[ch];
                     if (freq_op[ch] > 32'(FREQ_MAX_HZ)) begin
                        next_freq_l = 32'(FREQ_MAX_HZ);
                     end else if (freq_op[ch] < 32'(FREQ_MIN_HZ)) begin
                        next_freq_l = 32'(FREQ_MIN_HZ);
                     end else begin
                        next_freq_l = freq_op[ch];
                     end
                     next_post_cnt = 32'h0000_0000;
                     next_pre_cnt  = 33'h0_0000_0000;
                     next_state    = irq_level ? S_POST : S_SEEK;
                  end
               end
            end
            S_SEEK: begin
               if (pulse_done) begin
                  next_pre_cnt = pre_cnt + 33'h0_0000_0001;
               end
               if (!start) begin
                  next_kind  = END_ABORT;
                  next_state = S_STOP;
               end else if (limit_hit) begin
                  next_kind  = END_ABEND;
                  next_state = S_STOP;
               end else if (pulse_done && pre_cnt + 33'h0_0000_0001 >= PRE_LIMIT) begin
                  next_kind  = END_DONE;
                  next_state = S_STOP;
               end else if (irq_level && !irq_prev) begin
                  next_state = S_POST;
               end
            end
            S_POST: begin
               if (pulse_done) begin
                  next_post_cnt = post_cnt + 32'h0000_0001;
               end
               if (!start) begin
                  next_kind  = END_ABORT;
                  next_state = S_STOP;
               end else if (limit_hit) begin
                  next_kind  = END_ABEND;
                  next_state = S_STOP;
               end else if (post_cnt >= target ||
                            (pulse_done && post_cnt + 32'h0000_0001 >= target)) begin
                  next_kind  = END_DONE;
                  next_state = S_STOP;
               end
            end
            S_STOP: begin
               if (!pulse) begin
                  ev_done[ch]  = (kind == END_DONE);
                  ev_abend[ch] = (kind == END_ABEND);
                  next_state   = S_IDLE;
               end
            end
            default: begin
               next_state = S_IDLE;
            end
         endcase
      end

      // Channel flops
      always_ff @(posedge CLOCK) begin
         if (!NRST) begin
            state      <= S_IDLE;
            kind       <= END_ABORT;
            start_prev <= 1'b0;
            irq_prev   <= 1'b0;
            dir        <= 1'b0;
            freq_l     <= 32'h0000_0000;
            target     <= 32'h0000_0000;
            post_cnt   <= 32'h0000_0000;
            pre_cnt    <= 33'h0_0000_0000;
         end else begin
            state      <= next_state;
            kind       <= next_kind;
            start_prev <= start;
            irq_prev   <= irq_level;
            dir        <= next_dir;
            freq_l     <= next_freq_l;
            target     <= next_target;
            post_cnt   <= next_post_cnt;
            pre_cnt    <= next_pre_cnt;
         end
      end

      assign busy_int[ch]  = (state != S_IDLE);
      assign PULSE_OUT[ch] = pulse;
   end

   ////////////////////////////////////////////////////////////////////
   // Direction and busy pins
   always_ff @(posedge CLOCK) begin
      if (!NRST) begin
         DIRECTION_OUT <= 4'h0;
         BUSY          <= 4'h0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            DIRECTION_OUT[c] <= (c == 0) ? g_ch[0].next_dir :
                                (c == 1) ? g_ch[1].next_dir :
                                (c == 2) ? g_ch[2].next_dir : g_ch[3].next_dir;
         end
         BUSY <= {g_ch[3].next_state != S_IDLE, g_ch[2].next_state != S_IDLE,
                  g_ch[1].next_state != S_IDLE, g_ch[0].next_state != S_IDLE};
      end
   end
endmodule // irq_positioning
`default_nettype wire

// ---- tb/drive_model.sv ----
// Behavioural motor drive counting pulses per axis
`timescale 1ns/1ps
`default_nettype none
module drive_model (
   input  wire logic               clk,
   input  wire logic [3:0]         pulse,
   input  wire logic [3:0]         dir,
   output var  logic signed [31:0] pos [4]
);
   logic [3:0] pulse_q = 4'h0;
   initial pos = '{default: 32'sh0};
   ////////////////////////////////////////
   // Step on each rising pulse edge, sense from direction
   always @(posedge clk) begin
      pulse_q <= pulse;
      for (int i = 0; i < 4; i++) begin
         if (pulse[i] && !pulse_q[i]) begin
            pos[i] <= dir[i] ? pos[i] + 32'sh1 : pos[i] - 32'sh1;
         end
      end
   end
endmodule // drive_model
`default_nettype wire

// ---- tb/irq_positioning_checker.sv ----
// Concurrent checks on the interrupt positioning channel ports
`timescale 1ns/1ps
`default_nettype none
module irq_positioning_checker
   import irq_pos_pkg::*;
#(
   parameter logic [32:0] PRE_LIMIT = PRE_IRQ_LIMIT
) (
   input wire logic        CLOCK,
   input wire logic        NRST,
   input wire logic [7:0]  ADDR,
   input wire logic [31:0] WDATA,
   input wire logic        WR,
   input wire logic        RD,
   input wire logic [31:0] RDATA,
   input wire logic [7:0]  PHYS_IN,
   input wire logic [3:0]  PULSE_OUT,
   input wire logic [3:0]  DIRECTION_OUT,
   input wire logic [3:0]  BUSY
);
   // Longest stop wait, valid for pulse rates of 50 kHz and up
   localparam int STOP_MAX = 300;
   logic [31:0] ctrl_q, next_ctrl;
   logic [15:0] sel_q, next_sel;
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!NRST);
   ////////////////////////////////////////
   // Shadow copies of control and source select words
   always_comb begin
      next_ctrl = ctrl_q;
      next_sel = sel_q;
      if (WR && ADDR == REG_CTRL) begin
         next_ctrl = WDATA;
      end
      if (WR && ADDR == REG_SRC_SEL) begin
         next_sel = WDATA[15:0];
      end
      if (!NRST) begin
         next_ctrl = 32'h0;
         next_sel = SRC_SEL_RESET;
      end
   end
   always_ff @(posedge CLOCK) begin
      ctrl_q <= next_ctrl;
      sel_q <= next_sel;
   end
   ////////////////////////////////////////
   // Register port answers
   a_rdata_idle:
      assert property (!RD |=> RDATA == 32'h0)
      else $error("Read data not zero outside a read answer");
   a_status_busy:
      assert property ((RD && ADDR == REG_STATUS) |=> RDATA[3:0] == $past(BUSY))
      else $error("Status busy bits differ from busy pins");
   a_srcsel_read:
      assert property ((RD && ADDR == REG_SRC_SEL) |=> RDATA[15:0] == $past(sel_q))
      else $error("Source select word reads back wrong");
   ////////////////////////////////////////
   // Per channel motion checks
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      wire logic start_edge = WR && ADDR == REG_CTRL && WDATA[CTRL_START + c]
                              && !ctrl_q[CTRL_START + c];
      wire logic bad = WDATA[CTRL_SEL_EN] && sel_q[4*c +: 4] > SRC_USER;
      wire logic lim = DIRECTION_OUT[c] ? ctrl_q[CTRL_FWD_LIM + c] : ctrl_q[CTRL_REV_LIM + c];
      a_pulse_idle:
         assert property ((!BUSY[c] && !$past(BUSY[c])) |-> !PULSE_OUT[c])
         else $error("Pulse output while channel idle");
      a_dir_hold:
         assert property ((BUSY[c] && $past(BUSY[c])) |-> $stable(DIRECTION_OUT[c]))
         else $error("Direction changed during a move");
      a_busy_needs_start:
         assert property ((!ctrl_q[CTRL_START + c] && !start_edge && !BUSY[c]) |=> !BUSY[c])
         else $error("Busy rose without a start");
      a_abort_stops:
         assert property ($fell(ctrl_q[CTRL_START + c]) |-> ##[0:STOP_MAX] !BUSY[c])
         else $error("Channel kept running after start removed");
      a_limit_stops:
         assert property ((BUSY[c] && lim) |-> ##[0:STOP_MAX] !BUSY[c])
         else $error("Channel kept running into a limit");
      a_bad_no_motion:
         assert property ((start_edge && bad && !BUSY[c]) |=> (!BUSY[c]) [*4])
         else $error("Channel moved with a bad source field");
   end
endmodule // irq_positioning_checker

bind irq_positioning irq_positioning_checker #(.PRE_LIMIT(PRE_LIMIT)) u_checker (
   .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .PHYS_IN(PHYS_IN), .PULSE_OUT(PULSE_OUT),
   .DIRECTION_OUT(DIRECTION_OUT), .BUSY(BUSY)
);
`default_nettype wire

// ---- tb/test_irq_positioning.sv ----
// Self-checking bench for the interrupt positioning channels
`timescale 1ns/1ps
`default_nettype none
module test_irq_positioning
   import irq_pos_pkg::*;
;
   localparam int PRE = 5;
   logic               CLOCK = 1'b0;
   logic               NRST = 1'b0;
   logic               WR = 1'b0;
   logic               RD = 1'b0;
   logic [7:0]         ADDR = 8'h0;
   logic [7:0]         PHYS_IN = 8'h0;
   logic [31:0]        WDATA = 32'h0;
   logic [31:0]        RDATA, ctrl, got;
   logic [3:0]         PULSE_OUT, DIRECTION_OUT, BUSY;
   logic signed [31:0] pos [4];
   int                 errors = 0;
   int                 tests_run = 0;

   irq_positioning #(.PRE_LIMIT(33'(PRE))) dut (
      .CLOCK(CLOCK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .PHYS_IN(PHYS_IN), .PULSE_OUT(PULSE_OUT),
      .DIRECTION_OUT(DIRECTION_OUT), .BUSY(BUSY)
   );
   drive_model drv (.clk(CLOCK), .pulse(PULSE_OUT), .dir(DIRECTION_OUT), .pos(pos));

   // 20 MHz clock
   always #25 CLOCK = ~CLOCK;
   ////////////////////////////////////////
   // Bus cycles and waits
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 got = RDATA;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic fall(input int ch);
      int n;
      n = 0;
      while (PULSE_OUT[ch] !== 1'b1 && n < 3000) begin
         @(posedge CLOCK);
         n++;
      end
      while (PULSE_OUT[ch] !== 1'b0 && n < 6000) begin
         @(posedge CLOCK);
         n++;
      end
      chk(32'(n >= 3000), 32'h0);
   endtask
   task automatic idle(input int ch);
      int n;
      n = 0;
      repeat (20) if (BUSY[ch] !== 1'b1) @(posedge CLOCK);
      while (BUSY[ch] !== 1'b0 && n < 6000) begin
         @(posedge CLOCK);
         n++;
      end
      chk(32'(n >= 6000), 32'h0);
   endtask
   task automatic print_verdict();
      $display("Counts: %0d compared, %0d mismatched", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   // One move; kind 0 default pin, 1 chosen pin, 2 user command, 3 bad field,
   // 4 active at start, 5 no interrupt, 6 start removed, 7 limit
   task automatic run(input int kind);
      int                 ch;
      logic               inv;
      logic [3:0]         fld, src;
      logic [15:0]        sel;
      logic [7:0]         base;
      logic signed [31:0] cnt, snap;
      logic [31:0]        exp_st;
      @(posedge CLOCK);
      ch = $urandom_range(3);
      inv = (kind == 2) ? 1'b1 : 1'($urandom_range(1));
      cnt = $urandom_range(4, 1);
      if ($urandom_range(1)) cnt = -cnt;
      fld = (kind == 1) ? 4'($urandom_range(7)) : (kind == 3) ? 4'($urandom_range(15, 9)) : SRC_USER;
      src = (kind == 1) ? fld : 4'(ch);
      sel = 16'hffff;
      sel[4*ch +: 4] = fld;
      base = REG_CH_BASE + 8'(8 * ch);
      ctrl = {16'h0, {4{inv}}, 12'h0};
      ctrl[CTRL_SEL_EN] = (kind >= 1 && kind <= 3);
      if (kind == 7) ctrl[(cnt > 0 ? CTRL_REV_LIM : CTRL_FWD_LIM) + ch] = 1'b1;
      PHYS_IN <= (kind == 4) ? ({8{inv}} ^ (8'h01 << src)) : {8{inv}};
      wr(REG_SRC_SEL, {16'h0, sel});
      wr(base, cnt);
      wr(base + REG_FREQ_OFS, 32'($urandom_range(100000, 50000)));
      wr(REG_CTRL, ctrl);
      snap = pos[ch];
      ctrl[CTRL_START + ch] = 1'b1;
      wr(REG_CTRL, ctrl);
      if (kind == 3) begin
         repeat (4) @(posedge CLOCK);
         chk(32'(BUSY), 32'h0);
         rd(REG_ERR_CODE);
         chk(got, 32'(BAD_SOURCE_ERROR_CODE));
      end else if (kind == 4 || kind == 5) begin
         idle(ch);
         chk(pos[ch] - snap, kind == 4 ? cnt : (cnt > 0 ? PRE : -PRE));
      end else begin
         fall(ch);
         chk(32'(DIRECTION_OUT[ch]), 32'(cnt > 0));
         case (kind)
            2: ctrl[CTRL_USER + ch] = 1'b1;
            6: ctrl[CTRL_START + ch] = 1'b0;
            7: ctrl[(cnt > 0 ? CTRL_FWD_LIM : CTRL_REV_LIM) + ch] = 1'b1;
            default: PHYS_IN[src] <= ~inv;
         endcase
         if (kind >= 2) wr(REG_CTRL, ctrl);
         snap = pos[ch];
         if (kind < 2) begin
            repeat (4) @(posedge CLOCK);
            PHYS_IN[src] <= inv;
            repeat (4) @(posedge CLOCK);
            PHYS_IN[src] <= ~inv;
            wr(base, -cnt);
         end
         idle(ch);
         if (kind < 3) chk(pos[ch] - snap, cnt);
      end
      exp_st = 32'h0;
      exp_st[(kind == 3 ? STAT_ERR : kind == 7 ? STAT_ABEND : STAT_DONE) + ch] = (kind != 6);
      rd(REG_STATUS);
      chk(got, exp_st);
      ctrl = 32'h0;
      wr(REG_CTRL, ctrl);
      wr(REG_STATUS, 32'h0000fff0);
      $display("Test kind %0d on channel %0d ended", kind, ch);
   endtask
   ////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(32'hdfdbd309));
      repeat (3) @(posedge CLOCK);
      NRST <= 1'b1;
      rd(REG_SRC_SEL);
      chk(got, {16'h0, SRC_SEL_RESET});
      wr(8'hfc, 32'hffffffff);
      rd(8'hfc);
      chk(got, 32'h0);
      for (int k = 0; k < 8; k++) run(k);
      repeat (10) run($urandom_range(7));
      print_verdict();
   end
   // Watchdog
   initial begin
      #(80000 * 50);
      errors++;
      print_verdict();
   end
endmodule // test_irq_positioning
`default_nettype wire
